// *** rtl/dsl_lamp_ctrl.sv ***
// Drive status lamp control: error lamp, activity lamp and power gate.
`timescale 1ns/1ps
module dsl_lamp_ctrl #(
  parameter logic [dsl_pkg::CNT_W-1:0] ACT_PULSE  = dsl_pkg::CNT_W'(dsl_pkg::ACT_PULSE_CYC),
  parameter logic [dsl_pkg::CNT_W-1:0] FLASH_HALF = dsl_pkg::CNT_W'(dsl_pkg::FLASH_HALF_CYC),
  parameter logic [dsl_pkg::CNT_W-1:0] DESKEW     = dsl_pkg::CNT_W'(dsl_pkg::DESKEW_CYC)
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset,
  // Configuration strap, sampled while no contact is mated; high selects hot-plug patterns.
  input  wire logic hot_plug_mode,
  // Start and mated inputs from the connector, high when open.
  input  wire logic start_1_open,
  input  wire logic start_2_open,
  // Drive state.
  input  wire logic spin_up_active,
  input  wire logic spin_down_active,
  input  wire logic spin_ready,
  input  wire logic internal_failure,
  input  wire logic host_fault_req,
  input  wire logic command_rx,
  input  wire logic vendor_flash_req,
  // Loop bypass enables driven by the drive, active low.
  input  wire logic port_a_loop_bypass_n,
  input  wire logic port_b_loop_bypass_n,
  // Power control level at the pin, pulled up externally on the drive.
  input  wire logic power_control,
  // Error lamp open-drain pin.
  input  wire logic error_lamp_n_in,
  output logic      error_lamp_n_out,
  output logic      error_lamp_n_oe_n,
  // Activity lamp open-drain pin.
  input  wire logic activity_lamp_n_in,
  output logic      activity_lamp_n_out,
  output logic      activity_lamp_n_oe_n,
  // Status.
  output logic      mated,
  output logic      mated_settled,
  output logic      power_rails_on,
  output logic      error_lamp_seen,
  output logic      activity_lamp_seen
);
  // Strap and mating state.
  logic                      mode_hot_q;
  logic                      raw_mated;
  logic                      mated_q;
  logic                      settled_q;
  logic                      deskew_busy;
  logic                      deskew_start;
  dsl_pkg::dsl_spin_t        spin_st;

  // Activity pulse and flash divider.
  logic                      act_busy;
  logic                      flash_q;
  logic [dsl_pkg::CNT_W-1:0] flash_cnt_q;
  logic [dsl_pkg::CNT_W-1:0] flash_cnt_d;
  logic                      flash_tick;

  // Lamp decisions, pin registers and read-back.
  logic                      err_on;
  logic                      act_on;
  logic                      act_on_q;
  logic                      err_on_q;
  logic                      pwr_q;
  logic                      err_seen_q;
  logic                      act_seen_q;

  // Both members of a pair at their active level.
  function automatic logic both_set(input logic a, input logic b);
    return a & b;
  endfunction

  // Mated when either start input reads grounded.
  assign raw_mated    = ~both_set(start_1_open, start_2_open);
  assign deskew_start = raw_mated & ~mated_q;

  // Deskew timer restarts on each new mated indication.
  // Losing both contacts clears it, so a bouncing insertion waits the full time again.
  dsl_timer u_deskew (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (deskew_start),
    .clear    (~raw_mated),
    .load_val (DESKEW),
    .busy     (deskew_busy)
  );

  // Activity pulse timer retriggers on each command received while mated.
  // Unmating clears a running pulse so no stale blink follows a reinsertion.
  dsl_timer u_act (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (command_rx & mated_q),
    .clear    (~mated_q),
    .load_val (ACT_PULSE),
    .busy     (act_busy)
  );

  // Spin state as seen by the lamp patterns; spin-down wins at once.
  assign spin_st = spin_down_active ? dsl_pkg::DSL_SPIN_DOWN :
                   spin_up_active   ? dsl_pkg::DSL_SPIN_UP :
                   spin_ready       ? dsl_pkg::DSL_SPIN_READY :
                                      dsl_pkg::DSL_SPIN_STOPPED;

  // Half second flash divider.
  // The divider runs free, so a pattern may begin part way into a half period.
  assign flash_tick  = (flash_cnt_q == '0);
  assign flash_cnt_d = flash_tick ? FLASH_HALF - 1'b1 : flash_cnt_q - 1'b1;

  // Error lamp: both bypasses, failure or host request.
  assign err_on = both_set(~port_a_loop_bypass_n, ~port_b_loop_bypass_n)
                  | internal_failure | host_fault_req;

  // Activity lamp pattern selection.
  always_comb begin
    act_on = 1'b0;
    if (mated_q) begin
      case (spin_st)
        dsl_pkg::DSL_SPIN_UP, dsl_pkg::DSL_SPIN_DOWN: begin
          act_on = flash_q;
        end
        dsl_pkg::DSL_SPIN_READY: begin
          act_on = mode_hot_q ? ~act_busy : act_busy;
        end
        dsl_pkg::DSL_SPIN_STOPPED: begin
          act_on = act_busy;
        end
        default: begin
          act_on = 1'b0;
        end
      endcase
      if (vendor_flash_req) begin
        act_on = flash_q;
      end
    end
  end

  // Strap capture and mating state; the strap only moves while no contact is mated.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_hot_q <= 1'b1;
      mated_q    <= 1'b0;
      settled_q  <= 1'b0;
    end else begin
      if (!mated_q && !raw_mated) begin
        mode_hot_q <= hot_plug_mode;
      end
      mated_q    <= raw_mated;
      settled_q  <= raw_mated & mated_q & ~deskew_busy & ~deskew_start;
    end
  end

  // Free running half second flash divider shared by all flashing patterns.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flash_q     <= 1'b0;
      flash_cnt_q <= '0;
    end else begin
      flash_cnt_q <= flash_cnt_d;
      if (flash_tick) begin
        flash_q <= ~flash_q;
      end
    end
  end

  // Lamp and power registers; the mated gate keeps a stale decision off the pin.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_on_q <= 1'b0;
      err_on_q <= 1'b0;
      pwr_q    <= 1'b0;
    end else begin
      act_on_q <= act_on & mated_q;
      err_on_q <= err_on;
      pwr_q    <= power_control;
    end
  end

  // Pin read-back: a low pin with the driver released means the backplane pulls it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      err_seen_q <= 1'b0;
      act_seen_q <= 1'b0;
    end else begin
      err_seen_q <= ~error_lamp_n_in;
      act_seen_q <= ~activity_lamp_n_in;
    end
  end

  // Open-drain pins: drive low to light the lamp, release otherwise.
  // The output level is fixed low; only the enable moves, so the pin never drives high.
  assign error_lamp_n_out     = 1'b0;
  assign error_lamp_n_oe_n    = ~err_on_q;
  assign activity_lamp_n_out  = 1'b0;
  assign activity_lamp_n_oe_n = ~act_on_q;
  assign mated                = mated_q;
  assign mated_settled        = settled_q;
  assign power_rails_on       = pwr_q;
  assign error_lamp_seen      = err_seen_q;
  assign activity_lamp_seen   = act_seen_q;
endmodule // dsl_lamp_ctrl

// *** rtl/dsl_pkg.sv ***
// Package of constants for the drive status lamp control block.
package dsl_pkg;
  // Core clock rate in kHz and derived figures.
  localparam int unsigned CLK_KHZ          = 25000;
  // Flash half period in milliseconds.
  localparam int unsigned FLASH_HALF_MS    = 500;
  localparam int unsigned FLASH_HALF_CYC   = FLASH_HALF_MS * CLK_KHZ;
  // Mating deskew time in milliseconds.
  localparam int unsigned DESKEW_MS        = 250;
  localparam int unsigned DESKEW_CYC       = DESKEW_MS * CLK_KHZ;
  // Activity pulse length in milliseconds.
  localparam int unsigned ACT_PULSE_MS     = 100;
  localparam int unsigned ACT_PULSE_CYC    = ACT_PULSE_MS * CLK_KHZ;
  // Counter width large enough for every count above.
  localparam int unsigned CNT_W            = 24;
  // Spin states of the drive.
  typedef enum logic [1:0] {
    DSL_SPIN_STOPPED = 2'h0,
    DSL_SPIN_UP      = 2'h1,
    DSL_SPIN_READY   = 2'h3,
    DSL_SPIN_DOWN    = 2'h2
  } dsl_spin_t;
endpackage

// *** rtl/dsl_timer.sv ***
// Down counter that holds a level for a programmed number of cycles.
`timescale 1ns/1ps
module dsl_timer (
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Control.
  input  wire logic                        start,
  input  wire logic                        clear,
  input  wire logic [dsl_pkg::CNT_W-1:0]   load_val,
  // Status.
  output logic                             busy
);
  logic [dsl_pkg::CNT_W-1:0] cnt_q;
  logic [dsl_pkg::CNT_W-1:0] cnt_d;

  // Clear to zero first, else load on start, count down otherwise, stop at zero.
  assign cnt_d = clear ? '0 : start ? load_val :
                 (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign busy  = (cnt_q != '0);

  // Counter register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // dsl_timer

// *** verification/dsl_backplane_model.sv ***
// Backplane model: mating contacts, power control and lamp lines.
`timescale 1ns/1ps
module dsl_backplane_model (
  // Backplane controls.
  input wire logic mate_a,
  input wire logic mate_b,
  input wire logic pull_err,
  input wire logic cut_power,
  // Drive lamp enables.
  input wire logic err_oe_n,
  input wire logic act_oe_n,
  // Connector levels.
  output logic     s1_open,
  output logic     s2_open,
  output logic     pwr_ctl,
  output logic     err_in,
  output logic     act_in
);
  // Open contacts and released lines read high through pull-ups.
  assign s1_open = !mate_a;
  assign s2_open = !mate_b;
  assign pwr_ctl = !cut_power;
  assign err_in = !pull_err && err_oe_n;
  assign act_in = act_oe_n;
endmodule // dsl_backplane_model

// *** verification/dsl_lamp_ctrl_monitor.sv ***
// Checker of the lamp control port relations, bound to the design.
`timescale 1ns/1ps
module dsl_lamp_ctrl_monitor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Watched inputs.
  input wire logic port_a_loop_bypass_n,
  input wire logic port_b_loop_bypass_n,
  input wire logic internal_failure,
  input wire logic host_fault_req,
  input wire logic start_1_open,
  input wire logic start_2_open,
  input wire logic power_control,
  input wire logic error_lamp_n_in,
  // Watched outputs.
  input wire logic error_lamp_n_oe_n,
  input wire logic activity_lamp_n_oe_n,
  input wire logic mated,
  input wire logic mated_settled,
  input wire logic power_rails_on,
  input wire logic error_lamp_seen
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Any of the three fault causes asks for the error lamp.
  wire err_req = (!port_a_loop_bypass_n && !port_b_loop_bypass_n) || internal_failure
                 || host_fault_req;
  // Consecutive mated cycles, saturating, for the deskew check.
  logic [7:0] mate_run;
  always_ff @(posedge clk_sys) begin
    if (reset || !mated) begin
      mate_run <= 8'h00;
    end else if (mate_run != 8'hFF) begin
      mate_run <= mate_run + 8'h01;
    end
  end
  // Port relations.
  a_err_lamp_on: assert property (err_req |=> !error_lamp_n_oe_n)
    else $error("error lamp not lit");
  a_err_lamp_off: assert property (!err_req |=> error_lamp_n_oe_n)
    else $error("error lamp not released");
  a_mate_seen: assert property (!(start_1_open && start_2_open) |=> mated)
    else $error("mating missed");
  a_unmate_seen: assert property (start_1_open && start_2_open |=> !mated)
    else $error("unmating missed");
  a_power_follow: assert property (1'b1 |=> power_rails_on == $past(power_control))
    else $error("power rails wrong");
  a_unmated_dark: assert property (!mated [*3] |-> activity_lamp_n_oe_n)
    else $error("activity lamp lit unmated");
  a_wired_seen: assert property (!error_lamp_n_in |=> error_lamp_seen)
    else $error("pulled lamp unseen");
  a_settle_wait: assert property ($rose(mated_settled) |-> $past(mated, 25))
    else $error("settled too early");
  a_settle_held: assert property ($rose(mated_settled) |-> mate_run >= 8'h19)
    else $error("settled without a steady mating");
  // Main scenarios reached.
  c_settled: cover property ($rose(mated_settled));
  c_act_on: cover property (mated && $fell(activity_lamp_n_oe_n));
  c_wired: cover property (error_lamp_seen && error_lamp_n_oe_n);
endmodule // dsl_lamp_ctrl_monitor

bind dsl_lamp_ctrl dsl_lamp_ctrl_monitor u_mon (.clk_sys, .reset, .port_a_loop_bypass_n,
  .port_b_loop_bypass_n, .internal_failure, .host_fault_req, .start_1_open, .start_2_open,
  .power_control, .error_lamp_n_in, .error_lamp_n_oe_n, .activity_lamp_n_oe_n, .mated,
  .mated_settled, .power_rails_on, .error_lamp_seen);

// *** verification/dsl_lamp_ctrl_tb_top.sv ***
// Self-checking bench for the drive status lamp control block.
`timescale 1ns/1ps
module dsl_lamp_ctrl_tb_top;
  logic clk_sys, reset, hp, su, sd, rdy, fail, host, cmd, vf, ba, bb;
  logic mate_a, mate_b, pull_err, cut_power;
  wire logic s1_open, s2_open, pwr_ctl, err_in, act_in, eo, err_oe_n, act_oe_n, mt, ms, pr, es;
  wire logic ao, aseen;
  int n_errors = 0;
  int num_checks = 0;
  // Backplane and design.
  dsl_backplane_model bp (.mate_a, .mate_b, .pull_err, .cut_power, .err_oe_n, .act_oe_n,
    .s1_open, .s2_open, .pwr_ctl, .err_in, .act_in);
  dsl_lamp_ctrl #(.ACT_PULSE(24'h00_0014), .FLASH_HALF(24'h00_0010), .DESKEW(24'h00_001E)) DUT (
    .clk_sys, .reset, .hot_plug_mode(hp), .start_1_open(s1_open), .start_2_open(s2_open),
    .spin_up_active(su), .spin_down_active(sd), .spin_ready(rdy), .internal_failure(fail),
    .host_fault_req(host), .command_rx(cmd), .vendor_flash_req(vf), .port_a_loop_bypass_n(ba),
    .port_b_loop_bypass_n(bb), .power_control(pwr_ctl), .error_lamp_n_in(err_in),
    .error_lamp_n_out(eo), .error_lamp_n_oe_n(err_oe_n), .activity_lamp_n_in(act_in),
    .activity_lamp_n_out(ao), .activity_lamp_n_oe_n(act_oe_n), .mated(mt), .mated_settled(ms),
    .power_rails_on(pr), .error_lamp_seen(es), .activity_lamp_seen(aseen));
  // Core clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic pulse_cmd();
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    cyc(2);
  endtask
  // Every fault cause combination, then a backplane pull.
  task automatic t_error();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      {ba, bb, fail, host} = v;
      cyc(2);
      chk("err_oe_n", err_oe_n, (v[3] | v[2]) & ~v[1] & ~v[0]);
      chk("err_out", eo, 1'b0);
    end
    {ba, bb, fail, host} = 4'hC;
    cyc(2);
    chk("err_seen idle", es, 1'b0);
    pull_err = 1'b1;
    cyc(2);
    chk("err_seen", es, 1'b1);
    chk("err pulled", err_oe_n, 1'b1);
    pull_err = 1'b0;
  endtask
  // Power switch control driven low, then released.
  task automatic t_power();
    cut_power = 1'b1;
    cyc(2);
    chk("rails", pr, 1'b0);
    cut_power = 1'b0;
    cyc(2);
    chk("rails", pr, 1'b1);
  endtask
  // Activity patterns for one pattern set.
  task automatic t_act(input logic hot);
    logic a;
    hp = hot;
    cyc(4);
    pulse_cmd();
    chk("act unmated", act_oe_n, 1'b1);
    {mate_a, mate_b} = {!hot, hot};
    cyc(40);
    chk("mated", mt, 1'b1);
    chk("settled", ms, 1'b1);
    pulse_cmd();
    chk("act idle cmd", act_oe_n, 1'b0);
    cyc(25);
    chk("act idle", act_oe_n, 1'b1);
    rdy = 1'b1;
    cyc(3);
    chk("act ready", act_oe_n, !hot);
    chk("act seen", aseen, hot);
    chk("act out", ao, 1'b0);
    pulse_cmd();
    chk("act ready cmd", act_oe_n, hot);
    cyc(25);
    vf = 1'b1;
    cyc(3);
    a = act_oe_n;
    cyc(16);
    chk("act vendor", act_oe_n, !a);
    vf = 1'b0;
    {su, sd} = {!hot, hot};
    cyc(3);
    a = act_oe_n;
    cyc(16);
    chk("act flash", act_oe_n, !a);
    {su, sd, rdy} = 3'h0;
    cyc(3);
    chk("act stopped", act_oe_n, 1'b1);
    {mate_a, mate_b} = 2'h0;
  endtask
  // Main sequence.
  initial begin
    {reset, hp, ba, bb, su, sd, rdy, fail} = 8'hF0;
    {host, cmd, vf, mate_a, mate_b, pull_err, cut_power} = 7'h00;
    cyc(12);
    reset = 1'b0;
    cyc(2);
    t_error();
    t_power();
    t_act(1'b1);
    t_act(1'b0);
    results();
  end
  // Watchdog against a hang.
  initial begin
    #(40 * 3000);
    n_errors++;
    results();
  end
endmodule // dsl_lamp_ctrl_tb_top
